// [rtl/stre_pkg.sv]
package stre_pkg;

  // Register indices on the configuration port
  localparam logic [2:0]  IDX_TIMING     = 3'h0;
  localparam logic [2:0]  IDX_REFRESH    = 3'h1;
  localparam logic [2:0]  IDX_ECC_CFG    = 3'h2;
  localparam logic [2:0]  IDX_ECC_STATUS = 3'h3;
  localparam logic [2:0]  IDX_ERR_ADDR   = 3'h4;
  localparam logic [2:0]  IDX_ERR_LOG    = 3'h5;

  // Field positions, bit 0 is the register LSB
  localparam int          CAS_LATENCY_FIELD_LSB       = 23;
  localparam int          PTA_LSB        = 18;
  localparam int          CTP_LSB        = 16;
  localparam int          LDF_LSB        = 14;
  localparam int          REFRESH_TO_ACTIVATE_LSB       = 2;
  localparam int          RCD_LSB        = 0;
  localparam int          RTR_LSB        = 16;
  localparam int          ECC_CE_LSB     = 20;
  localparam int          ESR_LANE_LSB   = 28;
  localparam int          ESR_CBE_LSB    = 22;
  localparam int          ESR_CE_BIT     = 21;
  localparam int          ESR_UE_BIT     = 20;
  localparam int          ESR_BANK_LSB   = 16;
  localparam int          AP_BIT         = 10;
  localparam int          COL10_BIT      = 11;

  // Reset values and masks
  localparam logic [31:0] TR_RESET       = 32'h0085_4001;
  localparam logic [15:0] RTR_RESET      = 16'h05F0;
  localparam logic [15:0] RTR_MASK       = 16'h3FF8;
  localparam logic [31:0] ESR_MASK       = 32'hF0FF_0000;
  localparam logic [3:0]  EVEN_BANKS     = 4'h5;
  localparam logic [3:0]  ODD_BANKS      = 4'hA;

  // Cycle decode of timing codes
  localparam logic [3:0]  CYC_OFFSET     = 4'h1;
  localparam logic [3:0]  REFRESH_TO_ACTIVATE_OFFSET    = 4'h4;
  localparam logic [3:0]  REG_CAS_EXTRA  = 4'h1;
  localparam logic [3:0]  SYNC_STAGES    = 4'h2;

  // SDRAM commands as {ras_n, cas_n, we_n}
  typedef enum logic [2:0] {
    CMD_REF   = 3'b001,
    CMD_PRE   = 3'b010,
    CMD_ACT   = 3'b011,
    CMD_WRITE = 3'b100,
    CMD_READ  = 3'b101,
    CMD_NOP   = 3'b111
  } stre_cmd_t;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0000,
    ST_ACT      = 4'b0001,
    ST_RW       = 4'b0010,
    ST_CAPTURE  = 4'b0011,
    ST_MERGE    = 4'b0100,
    ST_PRE      = 4'b0101,
    ST_REF_EVEN = 4'b0110,
    ST_REF_ODD  = 4'b0111,
    ST_WAIT     = 4'b1000
  } stre_state_t;

  typedef struct packed {
    logic        ue;
    logic        ce;
    logic [1:0]  cbe;
    logic [3:0]  lane;
    logic [31:0] data;
  } stre_fix_t;

endpackage : stre_pkg

// [rtl/stre_sdram_core.sv]
`timescale 1ns/1ps
// Operation
// - 13x11x4 parts put column bit ten on address line eleven.
// - Reads fetch a whole doubleword, address bit zero low then high.
// - Timing register writes are ignored while the controller is enabled.
// - Registered mode adds one clock to the programmed CAS latency.
// - CAS latency codes 01, 10, 11 give 2, 3, 4 clocks.
// - Precharge to activate spacing from a two-bit code, 1 to 4.
// - Read or write to precharge spacing from a two-bit code.
// - Bank select follows address and command by the leadoff count.
// - Refresh to activate spacing, 4 to 11 cycles.
// - Activate to read or write spacing, 1 to 4 cycles.
// - Odd banks refresh staggered after even banks.
// - Only enabled banks are refreshed.
// - Refresh runs after initialization regardless of enable; accesses wait.
// - Interval counter on controller clock, field bits 3:13, reset 0x05F0.
// - Correct single errors, detect double and nibble errors on reads.
// - Reads and full writes add no latency; partial writes read first.
// - Per-bank correction enables; disabled banks pass data unmodified.
// - Corrected data goes to the master or merges into partial writes.
// - Correctable errors log bank, byte lane, check-bit half and flag.
// - Uncorrectable errors pass data, capture address, log master, flag.
// - Status bits written as one clear, zero bits stay.
module stre_sdram_core
  import stre_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_controller_enable,
  input  wire logic        i_registered_mode,
  input  wire logic        i_ecc_mode_select,
  input  wire logic [3:0]  i_bank_enable,
  input  wire logic        i_mode_13x11,
  input  wire logic        i_init_done,
  input  wire logic        i_reg_write,
  input  wire logic [2:0]  i_reg_index,
  input  wire logic [31:0] i_reg_wdata,
  output logic      [31:0] o_reg_rdata,
  input  wire logic        i_req_valid,
  output logic             o_req_ready,
  input  wire logic        i_req_write,
  input  wire logic        i_req_partial,
  input  wire logic [7:0]  i_req_byte_en,
  input  wire logic [63:0] i_req_wdata,
  input  wire logic [1:0]  i_req_bank,
  input  wire logic [1:0]  i_req_ba,
  input  wire logic [12:0] i_req_row,
  input  wire logic [10:0] i_req_col,
  input  wire logic [2:0]  i_req_master,
  output logic             o_done,
  output logic      [63:0] o_rd_data,
  output logic             o_rd_error,
  output logic      [12:0] o_memory_address_bus,
  output logic      [1:0]  o_bank_address_pins,
  output logic      [3:0]  o_bank_select_n,
  output logic             o_ras_n,
  output logic             o_cas_n,
  output logic             o_we_n,
  input  wire logic [31:0] i_mem_data,
  input  wire logic [7:0]  i_mem_check,
  output logic      [31:0] o_mem_data,
  output logic      [7:0]  o_mem_check,
  output logic             o_mem_data_oe_n
);

  typedef struct packed {
    stre_state_t state;
    stre_state_t ret;
    logic [3:0]  cnt;
    logic [2:0]  lead;
    logic        beat;
    logic        wr;
    logic        partial;
    logic [7:0]  be;
    logic [63:0] wdata;
    logic [1:0]  bank;
    logic [1:0]  ba;
    logic [12:0] row;
    logic [10:0] col;
    logic [2:0]  master;
    logic        uerr;
    logic [63:0] rdata;
    logic        done;
    stre_cmd_t   cmd;
    logic [12:0] addr;
    logic [3:0]  bsel_n;
    logic [31:0] dq;
    logic [7:0]  chk;
    logic        oe_n;
    logic [31:0] tr;
    logic [15:0] rtr;
    logic [3:0]  ecccfg;
    logic [31:0] esr;
    logic [31:0] err_addr;
    logic [3:0]  err_log;
    logic [31:0] reg_rdata;
    logic [15:0] rcnt;
    logic        ref_pend;
    logic        init_done;
    logic [39:0] sync1;
    logic [39:0] sync2;
  } stre_q_t;

  stre_q_t   q;
  stre_q_t   n;
  stre_fix_t fix;
  logic      ecc_en;
  logic      lead_done;
  logic [1:0] bank_bit;
  logic [3:0] sel_bank;
  logic [3:0] cas_c;
  logic [3:0] rcd_c;
  logic [3:0] ctp_c;
  logic [3:0] pta_c;
  logic [3:0] ldf_c;
  logic [3:0] refresh_to_activate_c;

  // Two-bit timing codes map to code plus one cycles
  function automatic logic [3:0] cyc_of(input logic [1:0] code);
    return 4'({2'b00, code}) + CYC_OFFSET;
  endfunction : cyc_of

  // Weight-three column of the check matrix for data bit idx
  function automatic logic [7:0] col_code(input int idx);
    logic [7:0] r;
    int         k;
    r = 8'h00;
    k = 0;
    for (int v = 0; v < 256; v++) begin
      if ($countones(8'(v)) == 3) begin
        if (k == idx) r = 8'(v);
        k++;
      end
    end
    return r;
  endfunction : col_code

  function automatic logic [7:0] ecc_gen(input logic [31:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 32; i++) begin
      if (d[i]) c = c ^ col_code(i);
    end
    return c;
  endfunction : ecc_gen

  // Odd-weight columns: even syndromes are never miscorrected
  function automatic stre_fix_t ecc_fix(input logic [31:0] d, input logic [7:0] chk, input logic en);
    stre_fix_t  r;
    logic [7:0] syn;
    r      = '0;
    r.data = d;
    syn    = ecc_gen(d) ^ chk;
    if (en && syn != 8'h00) begin
      if ($countones(syn) == 1) begin
        r.ce = 1'b1;
        r.cbe = (|syn[3:0]) ? 2'b01 : 2'b10;
      end else begin
        for (int i = 0; i < 32; i++) begin
          if (syn == col_code(i)) begin
            r.data[i] = ~d[i];
            r.lane[i / 8] = 1'b1;
            r.ce = 1'b1;
          end
        end
        r.ue = ~r.ce;
      end
    end
    return r;
  endfunction : ecc_fix

  // Decoded spacings from the timing register
  // registered latency adjust
  assign cas_c     = cyc_of(q.tr[CAS_LATENCY_FIELD_LSB +: 2]) + (i_registered_mode ? REG_CAS_EXTRA : 4'h0);
  assign rcd_c     = cyc_of(q.tr[RCD_LSB +: 2]);
  assign ctp_c     = cyc_of(q.tr[CTP_LSB +: 2]);
  assign pta_c     = cyc_of(q.tr[PTA_LSB +: 2]);
  assign ldf_c     = cyc_of(q.tr[LDF_LSB +: 2]);
  assign refresh_to_activate_c    = 4'({1'b0, q.tr[REFRESH_TO_ACTIVATE_LSB +: 3]}) + REFRESH_TO_ACTIVATE_OFFSET;
  assign lead_done = (q.lead == 3'(ldf_c));
  assign bank_bit  = 2'd3 - q.bank;
  assign sel_bank  = ~(4'h1 << q.bank);
  // correction only once enabled per bank
  assign ecc_en    = i_ecc_mode_select && q.ecccfg[bank_bit];
  assign fix       = ecc_fix(q.sync2[31:0], q.sync2[39:32], ecc_en);
  assign o_req_ready = (q.state == ST_IDLE) && !q.ref_pend && q.init_done && i_controller_enable;

  // Pins and answers straight from state flops
  assign o_reg_rdata          = q.reg_rdata;
  assign o_done               = q.done;
  assign o_rd_data            = q.rdata;
  assign o_rd_error           = q.uerr;
  assign o_memory_address_bus = q.addr;
  assign o_bank_address_pins  = q.ba;
  assign o_bank_select_n      = q.bsel_n;
  assign {o_ras_n, o_cas_n, o_we_n} = q.cmd;
  assign o_mem_data           = q.dq;
  assign o_mem_check          = q.chk;
  assign o_mem_data_oe_n      = q.oe_n;

  // Next state of the whole block
  always_comb begin
    n = q;
    n.cmd    = CMD_NOP;
    n.bsel_n = 4'hF;
    n.oe_n   = 1'b1;
    n.done   = 1'b0;
    n.sync1  = {i_mem_check, i_mem_data};
    n.sync2  = q.sync1;
    n.init_done = q.init_done | i_init_done;
    // Register writes; status clears before events so a new error wins
    if (i_reg_write) begin
      if (i_reg_index == IDX_TIMING) begin
        if (!i_controller_enable) n.tr = i_reg_wdata;
      end else if (i_reg_index == IDX_REFRESH) begin
        n.rtr = i_reg_wdata[RTR_LSB +: 16] & RTR_MASK;
      end else if (i_reg_index == IDX_ECC_CFG) begin
        n.ecccfg = i_reg_wdata[ECC_CE_LSB +: 4];
      end else if (i_reg_index == IDX_ECC_STATUS) begin
        n.esr = q.esr & ~(i_reg_wdata & ESR_MASK);
      end
    end
    // Read mux, registered for a clean data output
    if (i_reg_index == IDX_TIMING) n.reg_rdata = q.tr;
    else if (i_reg_index == IDX_REFRESH) n.reg_rdata = 32'(q.rtr) << RTR_LSB;
    else if (i_reg_index == IDX_ECC_CFG) n.reg_rdata = 32'(q.ecccfg) << ECC_CE_LSB;
    else if (i_reg_index == IDX_ECC_STATUS) n.reg_rdata = q.esr;
    else if (i_reg_index == IDX_ERR_ADDR) n.reg_rdata = q.err_addr;
    else if (i_reg_index == IDX_ERR_LOG) n.reg_rdata = 32'(q.err_log);
    else n.reg_rdata = 32'h0000_0000;
    // Command sequencer: closed page, one doubleword per access
    case (q.state)
      ST_IDLE: begin
        n.lead = 3'h0;
        n.beat = 1'b0;
        if (q.ref_pend) begin
          n.ref_pend = 1'b0;
          n.state    = ST_REF_EVEN;
        end else if (i_req_valid && o_req_ready) begin
          n.wr      = i_req_write;
          n.partial = i_req_write && i_req_partial;
          n.be      = i_req_byte_en;
          n.wdata   = i_req_wdata;
          n.bank    = i_req_bank;
          n.ba      = i_req_ba;
          n.row     = i_req_row;
          n.col     = i_req_col;
          n.master  = i_req_master;
          n.uerr    = 1'b0;
          n.state   = ST_ACT;
        end
      end
      ST_ACT: begin
        n.cmd  = CMD_ACT;
        n.addr = q.row;
        n.lead = q.lead + 3'h1;
        if (lead_done) begin
          n.bsel_n = sel_bank;
          n.lead   = 3'h0;
          n.cnt    = rcd_c - 4'h1;
          n.ret    = ST_RW;
          n.state  = ST_WAIT;
        end
      end
      ST_RW: begin
        n.cmd  = (q.wr && !q.partial) ? CMD_WRITE : CMD_READ;
        n.addr = 13'h0000;
        n.addr[9:0] = {q.col[9:1], q.beat};
        n.addr[AP_BIT] = 1'b0;
        n.addr[COL10_BIT] = i_mode_13x11 & q.col[10];
        if (q.wr && !q.partial) begin
          n.dq   = q.beat ? q.wdata[31:0] : q.wdata[63:32];
          n.chk  = ecc_gen(n.dq);
          n.oe_n = 1'b0;
        end
        n.lead = q.lead + 3'h1;
        // Second beat follows at once, bank select held
        if (lead_done || q.beat) begin
          n.bsel_n = sel_bank;
          n.lead   = 3'h0;
          n.beat   = ~q.beat;
          if (q.beat && q.wr && !q.partial) begin
            n.done  = 1'b1;
            n.cnt   = ctp_c - 4'h1;
            n.ret   = ST_PRE;
            n.state = ST_WAIT;
          end else if (q.beat) begin
            n.cnt   = cas_c + SYNC_STAGES - 4'h1;
            n.state = ST_CAPTURE;
          end
        end
      end
      ST_CAPTURE: begin
        if (q.cnt != 4'h0) begin
          n.cnt = q.cnt - 4'h1;
        end else begin
          n.beat = ~q.beat;
          if (!q.beat) n.rdata[63:32] = fix.data;
          else n.rdata[31:0] = fix.data;
          if (fix.ce) begin
            n.esr[ESR_LANE_LSB +: 4] = q.esr[ESR_LANE_LSB +: 4] | fix.lane;
            n.esr[ESR_CBE_LSB +: 2]  = q.esr[ESR_CBE_LSB +: 2] | fix.cbe;
            n.esr[ESR_CE_BIT] = 1'b1;
            n.esr[ESR_BANK_LSB + 32'(bank_bit)] = 1'b1;
          end
          if (fix.ue) begin
            n.esr[ESR_UE_BIT] = 1'b1;
            n.esr[ESR_BANK_LSB + 32'(bank_bit)] = 1'b1;
            n.err_addr = {4'h0, q.bank, q.ba, q.row, q.col};
            n.err_log  = {~q.wr, q.master};
            n.uerr     = 1'b1;
          end
          if (q.beat && q.partial) begin
            n.state = ST_MERGE;
          end else if (q.beat) begin
            n.done  = 1'b1;
            n.cnt   = ctp_c - 4'h1;
            n.ret   = ST_PRE;
            n.state = ST_WAIT;
          end
        end
      end
      ST_MERGE: begin
        for (int i = 0; i < 8; i++) begin
          n.wdata[i*8 +: 8] = q.be[i] ? q.wdata[i*8 +: 8] : q.rdata[i*8 +: 8];
        end
        n.partial = 1'b0;
        n.lead    = 3'h0;
        n.beat    = 1'b0;
        n.state   = ST_RW;
      end
      ST_PRE: begin
        n.cmd  = CMD_PRE;
        n.addr = 13'h0000;
        n.lead = q.lead + 3'h1;
        if (lead_done) begin
          n.bsel_n = sel_bank;
          n.lead   = 3'h0;
          n.cnt    = pta_c - 4'h1;
          n.ret    = ST_IDLE;
          n.state  = ST_WAIT;
        end
      end
      ST_REF_EVEN, ST_REF_ODD: begin
        n.cmd  = CMD_REF;
        n.addr = 13'h0000;
        n.lead = q.lead + 3'h1;
        if (lead_done) begin
          n.lead = 3'h0;
          if (q.state == ST_REF_EVEN) begin
            n.bsel_n = ~(i_bank_enable & EVEN_BANKS);
            n.state  = ST_REF_ODD;
          end else begin
            n.bsel_n = ~(i_bank_enable & ODD_BANKS);
            n.cnt    = refresh_to_activate_c - 4'h1;
            n.ret    = ST_IDLE;
            n.state  = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        n.lead = 3'h0;
        if (q.cnt == 4'h0) n.state = q.ret;
        else n.cnt = q.cnt - 4'h1;
      end
      default: n.state = ST_IDLE;
    endcase
    // timer free of enable once started
    if (q.init_done) begin
      if (q.rcnt == 16'h0000) begin
        n.ref_pend = 1'b1;
        n.rcnt     = q.rtr;
      end else begin
        n.rcnt = q.rcnt - 16'h0001;
      end
    end
  end

  // State register
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      q        <= '0;
      q.tr     <= TR_RESET;
      q.rtr    <= RTR_RESET;
      q.rcnt   <= RTR_RESET;
      q.cmd    <= CMD_NOP;
      q.bsel_n <= 4'hF;
      q.oe_n   <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // Spacing monitors, ages since each command took effect, refresh since it was last driven
  logic       eff;
  logic [4:0] since_act;
  logic [4:0] since_pre;
  logic [4:0] since_rw;
  logic [4:0] since_ref;
  assign eff = ~&o_bank_select_n;

  function automatic logic [4:0] age(input logic hit, input logic [4:0] c);
    return hit ? 5'h01 : ((c == 5'h1F) ? c : c + 5'h01);
  endfunction : age

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      since_act <= 5'h1F;
      since_pre <= 5'h1F;
      since_rw  <= 5'h1F;
      since_ref <= 5'h1F;
    end else begin
      since_act <= age(eff && q.cmd == CMD_ACT, since_act);
      since_pre <= age(eff && q.cmd == CMD_PRE, since_pre);
      since_rw  <= age(eff && (q.cmd == CMD_READ || q.cmd == CMD_WRITE), since_rw);
      since_ref <= age(q.cmd == CMD_REF, since_ref);
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  property p_tr_locked;
    (i_reg_write && i_reg_index == IDX_TIMING && i_controller_enable) |=> $stable(q.tr);
  endproperty
  a_tr_locked: assert property (p_tr_locked) else $error("timing register changed while enabled");

  property p_reg_cas;
    ($rose(q.state == ST_CAPTURE) && i_registered_mode && q.tr[CAS_LATENCY_FIELD_LSB +: 2] == 2'b01) |-> q.cnt == 4'h4;
  endproperty
  a_reg_cas: assert property (p_reg_cas) else $error("registered CAS latency not three");

  property p_plain_cas;
    ($rose(q.state == ST_CAPTURE) && !i_registered_mode && q.tr[CAS_LATENCY_FIELD_LSB +: 2] == 2'b11) |-> q.cnt == 4'h5;
  endproperty
  a_plain_cas: assert property (p_plain_cas) else $error("CAS latency code 11 not four clocks");

  property p_lead;
    ($changed(q.cmd) && q.cmd != CMD_NOP) |-> (o_bank_select_n == 4'hF) ##1 $stable(q.cmd);
  endproperty
  a_lead: assert property (p_lead) else $error("bank select with new command, no leadoff");

  property p_rcd;
    (eff && (q.cmd == CMD_READ || q.cmd == CMD_WRITE)) |-> since_act >= 5'(rcd_c);
  endproperty
  a_rcd: assert property (p_rcd) else $error("activate to command too short");

  property p_pta;
    (eff && q.cmd == CMD_ACT) |-> since_pre >= 5'(pta_c);
  endproperty
  a_pta: assert property (p_pta) else $error("precharge to activate too short");

  property p_ctp;
    (eff && q.cmd == CMD_PRE) |-> since_rw >= 5'(ctp_c);
  endproperty
  a_ctp: assert property (p_ctp) else $error("command to precharge too short");

  property p_refresh_to_activate;
    (eff && q.cmd == CMD_ACT) |-> since_ref >= 5'(refresh_to_activate_c);
  endproperty
  a_refresh_to_activate: assert property (p_refresh_to_activate) else $error("refresh to activate too short");

  property p_stagger;
    (q.cmd == CMD_REF) |-> ((~o_bank_select_n & EVEN_BANKS) == 4'h0 || (~o_bank_select_n & ODD_BANKS) == 4'h0);
  endproperty
  a_stagger: assert property (p_stagger) else $error("even and odd banks refreshed together");

  property p_ref_enabled;
    (q.cmd == CMD_REF) |-> (~o_bank_select_n & ~i_bank_enable) == 4'h0;
  endproperty
  a_ref_enabled: assert property (p_ref_enabled) else $error("disabled bank refreshed");

  property p_w1c;
    (i_reg_write && i_reg_index == IDX_ECC_STATUS && i_reg_wdata == 32'hFFFF_FFFF
      && !(q.state == ST_CAPTURE && q.cnt == 4'h0)) |=> q.esr == 32'h0000_0000;
  endproperty
  a_w1c: assert property (p_w1c) else $error("status bits not cleared by ones");

  property p_ref_blocks;
    (q.ref_pend) |-> !o_req_ready;
  endproperty
  a_ref_blocks: assert property (p_ref_blocks) else $error("access accepted with refresh pending");

endmodule : stre_sdram_core

// [test/stre_mem_model.sv]
`timescale 1ns/1ps
// Behavioural memory: answers each read select after the CAS latency
module stre_mem_model
  import stre_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_registered_mode,
  input  wire logic [12:0] i_memory_address_bus,
  input  wire logic [3:0]  i_bank_select_n,
  input  wire logic        i_ras_n,
  input  wire logic        i_cas_n,
  input  wire logic        i_we_n,
  output logic      [31:0] o_mem_data,
  output logic      [7:0]  o_mem_check,
  output logic      [7:0]  o_ref_sel,
  output logic             o_col10
);
  localparam logic [31:0] BEAT0 = 32'hA5C3_1E70;
  localparam logic [31:0] BEAT1 = 32'h5A3C_E18F;
  logic [1:0] pipe [8];
  int         ref_n = 0;
  initial begin
    o_mem_data = 32'h0000_0000;
    o_mem_check = 8'h00;
    o_ref_sel = 8'h00;
    o_col10 = 1'b0;
    foreach (pipe[k]) pipe[k] = 2'b00;
  end
  // Idle pins show the inverse of the last value, never a stale word
  always @(posedge i_clock) begin
    for (int k = 0; k < 7; k++) pipe[k] = pipe[k+1];
    pipe[7] = 2'b00;
    o_mem_data <= pipe[0][1] ? (pipe[0][0] ? BEAT1 : BEAT0) : ~o_mem_data;
    o_mem_check <= ~o_mem_check;
    if (i_bank_select_n != 4'hF) begin
      if ({i_ras_n, i_cas_n, i_we_n} == CMD_REF && ref_n < 2) begin
        o_ref_sel[4*ref_n +: 4] <= i_bank_select_n;
        ref_n++;
      end
      if ({i_ras_n, i_cas_n, i_we_n} == CMD_READ) begin
        pipe[1 + int'(i_registered_mode)] = {1'b1, i_memory_address_bus[0]};
        if (!i_memory_address_bus[0]) o_col10 <= i_memory_address_bus[COL10_BIT];
      end
    end
  end
endmodule : stre_mem_model

// [test/tb_stre_sdram_core.sv]
`timescale 1ns/1ps
module tb_stre_sdram_core
  import stre_pkg::*;
;
  logic        i_clock = 1'b0, i_rst = 1'b1, en = 1'b0, regm = 1'b0, init = 1'b0, m13 = 1'b1;
  logic        wr = 1'b0, valid = 1'b0, o_req_ready, o_done, o_rd_error, ras_n, cas_n, we_n, oe_n, col10;
  logic [2:0]  idx = 3'h0;
  logic [31:0] wd = 32'h0000_0000, o_reg_rdata, mdata, odata, r;
  logic [10:0] col = 11'h000;
  logic [63:0] o_rd_data, d;
  logic [12:0] addr;
  logic [1:0]  ba, bank = 2'h0;
  logic [3:0]  bsel_n, ben = 4'h3;
  logic        ecc = 1'b1, rw = 1'b0, part = 1'b0;
  logic [7:0]  mcheck, ocheck, ref_sel;
  logic        e;
  int          fails = 0, check_count = 0, n;
  always #12.5 i_clock = ~i_clock;
  stre_sdram_core i_stre_sdram_core (.i_clock(i_clock), .i_rst(i_rst), .i_controller_enable(en),
    .i_registered_mode(regm), .i_ecc_mode_select(ecc), .i_bank_enable(ben), .i_mode_13x11(m13),
    .i_init_done(init), .i_reg_write(wr), .i_reg_index(idx), .i_reg_wdata(wd), .o_reg_rdata(o_reg_rdata),
    .i_req_valid(valid), .o_req_ready(o_req_ready), .i_req_write(rw), .i_req_partial(part),
    .i_req_byte_en(8'h00), .i_req_wdata(64'h0123_4567_89AB_CDEF), .i_req_bank(bank), .i_req_ba(2'h1),
    .i_req_row(13'h0123), .i_req_col(col), .i_req_master(3'h1), .o_done(o_done), .o_rd_data(o_rd_data),
    .o_rd_error(o_rd_error), .o_memory_address_bus(addr), .o_bank_address_pins(ba),
    .o_bank_select_n(bsel_n), .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n), .i_mem_data(mdata),
    .i_mem_check(mcheck), .o_mem_data(odata), .o_mem_check(ocheck), .o_mem_data_oe_n(oe_n));
  stre_mem_model i_stre_mem_model (.i_clock(i_clock), .i_registered_mode(regm),
    .i_memory_address_bus(addr), .i_bank_select_n(bsel_n), .i_ras_n(ras_n), .i_cas_n(cas_n),
    .i_we_n(we_n), .o_mem_data(mdata), .o_mem_check(mcheck), .o_ref_sel(ref_sel), .o_col10(col10));
  // Comparison with four-state equality so unknowns never match
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic reg_wr(input logic [2:0] i, input logic [31:0] v);
    @(negedge i_clock);
    wr = 1'b1;
    idx = i;
    wd = v;
    @(negedge i_clock);
    wr = 1'b0;
  endtask : reg_wr
  // Read data shows the index of the previous cycle
  task automatic reg_rd(input logic [2:0] i, output logic [31:0] v);
    @(negedge i_clock);
    idx = i;
    @(negedge i_clock);
    v = o_reg_rdata;
  endtask : reg_rd
  // Bounded waits so a stuck handshake cannot hang the run
  task automatic mem_rd(input logic [10:0] c);
    @(negedge i_clock);
    col = c;
    valid = 1'b1;
    for (n = 0; n < 4000 && o_req_ready !== 1'b1; n++) @(negedge i_clock);
    if (n == 4000) fails++;
    @(negedge i_clock);
    valid = 1'b0;
    for (n = 0; n < 300 && o_done !== 1'b1; n++) @(negedge i_clock);
    if (n == 300) fails++;
    d = o_rd_data;
    e = o_rd_error;
  endtask : mem_rd
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  initial begin
    #(25 * 20000);
    fails++;
    finish_test();
  end
  initial begin
    repeat (4) @(negedge i_clock);
    i_rst = 1'b0;
    reg_rd(IDX_TIMING, r);
    check(r, TR_RESET);
    reg_rd(IDX_REFRESH, r);
    check(r, {RTR_RESET, 16'h0000});
    reg_rd(3'h6, r);
    check(r, 32'h0000_0000);
    reg_wr(IDX_TIMING, 32'h0085_4005);
    reg_wr(IDX_ECC_CFG, 32'h0070_0000);
    reg_rd(IDX_ECC_CFG, r);
    check(r, 32'h0070_0000);
    en = 1'b1;
    init = 1'b1;
    reg_wr(IDX_TIMING, 32'h0085_4001);
    reg_rd(IDX_TIMING, r);
    check(r, 32'h0085_4005);
    $display("register test done");
    mem_rd(11'h400);
    check(d, 64'hA5C3_1E70_5A3C_E18F);
    check(e, 1'b0);
    check(col10, 1'b1);
    regm = 1'b1;
    m13 = 1'b0;
    mem_rd(11'h400);
    check(d, 64'hA5C3_1E70_5A3C_E18F);
    check(col10, 1'b0);
    reg_wr(IDX_ECC_STATUS, 32'hFFFF_FFFF);
    reg_rd(IDX_ECC_STATUS, r);
    check(r, 32'h0000_0000);
    rw = 1'b1;
    mem_rd(11'h000);
    rw = 1'b0;
    check(odata, 32'h89AB_CDEF);
    check(oe_n, 1'b0);
    $display("read test done");
    for (n = 0; n < 3000 && ref_sel[7:4] == 4'h0; n++) @(negedge i_clock);
    check(ref_sel[3:0], 4'hE);
    check(ref_sel[7:4], 4'hD);
    reg_wr(IDX_REFRESH, 32'hFFFF_FFFF);
    reg_rd(IDX_REFRESH, r);
    check(r, 32'h3FF8_0000);
    $display("refresh test done");
    finish_test();
  end
endmodule : tb_stre_sdram_core
